/* File: dpp_pkg.sv */
// Purpose: Constants for the DAC power and protection control block
// Assumes: 24-bit serial word, 32-bit APB data
// Notes:   APB offsets and control bit positions are local choices
package dpp_pkg;
    // ------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------
    localparam int       WORD_BITS  = 24;
    localparam int       RW_BIT     = 23;
    localparam int       REG_HI     = 21;
    localparam int       REG_LO     = 19;
    localparam int       ADR_HI     = 18;
    localparam int       ADR_LO     = 16;
    localparam int       DATA_BITS  = 16;
    localparam logic [2:0] REG_DAC  = 3'h0;
    localparam logic [2:0] REG_PWR  = 3'h2;
    localparam logic [2:0] REG_CTL  = 3'h3;
    localparam logic [2:0] ADR_A    = 3'h0;
    localparam logic [2:0] ADR_B    = 3'h2;
    localparam logic [2:0] ADR_BOTH = 3'h4;
    localparam logic [2:0] ADR_SET  = 3'h1;
    localparam logic [2:0] ADR_LOAD = 3'h4;
    // ------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------
    localparam int PU_POS [2]  = '{0, 2};
    localparam int OC_POS [2]  = '{7, 9};
    localparam int REFERENCE_POWER_UP_BIT_POS  = 4;
    localparam int TSD_POS     = 5;
    localparam int CTL_CLAMP   = 2;
    localparam int CTL_TSD_EN  = 3;
    localparam logic CLAMP_RST = 1'b1;
    // ------------------------------------------------------------
    // Pin synchroniser slots
    // ------------------------------------------------------------
    localparam int S_SCLK = 0;
    localparam int S_SYNC = 1;
    localparam int S_SDI  = 2;
    localparam int S_LOAD = 3;
    localparam int S_OC   = 4;
    localparam int S_OT   = 6;
    localparam int S_SUP  = 7;
    // Reset values equal the idle pin levels, except supply which starts low, so no false edge follows reset
    localparam logic [7:0] SYNC_RST = 8'h0B;
    // ------------------------------------------------------------
    // APB map and interrupt bits
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_PWR  = 12'h000;
    localparam logic [11:0] OFS_CTL  = 12'h004;
    localparam logic [11:0] OFS_ISTA = 12'h008;
    localparam logic [11:0] OFS_IMSK = 12'h00C;
    localparam int IRQ_BITS = 4;
    localparam int IRQ_WORD = 0;
    localparam int IRQ_OC   = 1;
    localparam int IRQ_TSD  = 3;
endpackage

/* File: dpp_ctrl.sv */
// Purpose: Power, clamp, fault and serial command logic of a dual DAC
// Assumes: pclk 10 MHz; serial pins and fault detectors are asynchronous
// Notes:   clk_en low freezes all state and stalls APB
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module dpp_ctrl (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // Serial link
    input  wire logic        serial_clock,
    input  wire logic        serial_sync_n,
    input  wire logic        serial_data_input,
    input  wire logic        load_output_strobe_n,
    output logic             serial_data_output,
    // Analog sense
    input  wire logic        supply_good,
    input  wire logic [1:0]  overcurrent_detect,
    input  wire logic        overtemp_detect,
    // Analog control
    output logic      [15:0] dac_code_a,
    output logic      [15:0] dac_code_b,
    output logic      [1:0]  output_clamp,
    output logic      [1:0]  amp_connect,
    output logic             reference_power_up
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [7:0]  pin_raw;
    logic [7:0]  s1_reg;
    logic [7:0]  s2_reg;
    logic [7:0]  s3_reg;
    logic [7:0]  filt_reg;
    logic [7:0]  filt_d_reg;
    assign pin_raw = {supply_good, overtemp_detect, overcurrent_detect,
                      load_output_strobe_n, serial_data_input, serial_sync_n, serial_clock};

    for (genvar i = 0; i < 8; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_reg[i]     <= dpp_pkg::SYNC_RST[i];
                s2_reg[i]     <= dpp_pkg::SYNC_RST[i];
                s3_reg[i]     <= dpp_pkg::SYNC_RST[i];
                filt_reg[i]   <= dpp_pkg::SYNC_RST[i];
                filt_d_reg[i] <= dpp_pkg::SYNC_RST[i];
            end else if (clk_en) begin
                s1_reg[i]     <= pin_raw[i];
                s2_reg[i]     <= s1_reg[i];
                s3_reg[i]     <= s2_reg[i];
                // Only a level seen twice counts, so a one-cycle glitch never lands
                if (s2_reg[i] == s3_reg[i]) begin
                    filt_reg[i] <= s3_reg[i];
                end
                filt_d_reg[i] <= filt_reg[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    logic        sclk_fall;
    logic        sclk_rise;
    logic        sync_start;
    logic        sync_end;
    logic        in_frame;
    logic        word_done;
    logic        load_fall;
    logic        load_low;
    logic [23:0] shift_reg;
    logic [4:0]  bit_cnt_reg;
    logic [23:0] rd_shift_reg;
    logic [23:0] rb_reg;
    assign in_frame   = ~filt_reg[dpp_pkg::S_SYNC];
    assign sclk_fall  = filt_d_reg[dpp_pkg::S_SCLK] & ~filt_reg[dpp_pkg::S_SCLK];
    assign sclk_rise  = ~filt_d_reg[dpp_pkg::S_SCLK] & filt_reg[dpp_pkg::S_SCLK];
    assign sync_start = filt_d_reg[dpp_pkg::S_SYNC] & in_frame;
    assign sync_end   = ~filt_d_reg[dpp_pkg::S_SYNC] & ~in_frame;
    assign word_done  = sync_end & (bit_cnt_reg == 5'(dpp_pkg::WORD_BITS));
    assign load_low   = ~filt_reg[dpp_pkg::S_LOAD];
    assign load_fall  = filt_d_reg[dpp_pkg::S_LOAD] & load_low;
    assign serial_data_output = rd_shift_reg[23];

    // ------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------
    logic        w_rd;
    logic [2:0]  w_reg;
    logic [2:0]  w_adr;
    logic [15:0] w_data;
    logic        wr_dac;
    logic        wr_pwr;
    logic        wr_set;
    logic        wr_load;
    assign w_rd    = shift_reg[dpp_pkg::RW_BIT];
    assign w_reg   = shift_reg[dpp_pkg::REG_HI:dpp_pkg::REG_LO];
    assign w_adr   = shift_reg[dpp_pkg::ADR_HI:dpp_pkg::ADR_LO];
    assign w_data  = shift_reg[dpp_pkg::DATA_BITS-1:0];
    assign wr_dac  = word_done & ~w_rd & (w_reg == dpp_pkg::REG_DAC);
    assign wr_pwr  = word_done & ~w_rd & (w_reg == dpp_pkg::REG_PWR);
    assign wr_set  = word_done & ~w_rd & (w_reg == dpp_pkg::REG_CTL)
                   & (w_adr == dpp_pkg::ADR_SET);
    assign wr_load = word_done & ~w_rd & (w_reg == dpp_pkg::REG_CTL)
                   & (w_adr == dpp_pkg::ADR_LOAD);

    // ------------------------------------------------------------
    // Global state
    // ------------------------------------------------------------
    logic        valid_reg;
    logic        clamp_en_reg;
    logic        tsd_en_reg;
    logic        tsd_flag_reg;
    logic        ref_pu_reg;
    logic        therm_trip;
    logic [1:0]  pu_reg;
    logic [1:0]  oc_flag_reg;
    logic [1:0]  oc_flag_next;
    logic [1:0]  oc_now;
    logic [15:0] dac_in_reg [2];
    logic [15:0] dac_out_reg [2];
    logic [15:0] pwr_word;
    logic [15:0] rb_data;
    assign oc_now     = filt_reg[dpp_pkg::S_OC +: 2];
    assign therm_trip = tsd_en_reg & filt_reg[dpp_pkg::S_OT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg    <= 1'b0;
            clamp_en_reg <= dpp_pkg::CLAMP_RST;
            tsd_en_reg   <= 1'b0;
            tsd_flag_reg <= 1'b0;
            ref_pu_reg   <= 1'b0;
        end else if (clk_en) begin
            // Dropping supply re-arms the power-up clamp
            valid_reg <= filt_reg[dpp_pkg::S_SUP] & (valid_reg | wr_dac);
            if (wr_set) begin
                clamp_en_reg <= w_data[dpp_pkg::CTL_CLAMP];
                tsd_en_reg   <= w_data[dpp_pkg::CTL_TSD_EN];
            end
            // Alert stays until the power register is rewritten; a new trip wins
            tsd_flag_reg <= therm_trip | (tsd_flag_reg & ~wr_pwr);
            if (wr_pwr) begin
                ref_pu_reg <= w_data[dpp_pkg::REFERENCE_POWER_UP_BIT_POS];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-channel power, fault and output
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic        hit;
        logic        trip;
        logic        revive;
        logic        upd;
        logic [15:0] in_next;
        assign hit     = wr_dac & ((w_adr == (c == 0 ? dpp_pkg::ADR_A : dpp_pkg::ADR_B))
                       | (w_adr == dpp_pkg::ADR_BOTH));
        assign trip    = oc_now[c] & ~clamp_en_reg & pu_reg[c];
        assign revive  = wr_pwr & w_data[dpp_pkg::PU_POS[c]];
        assign in_next = hit ? w_data : dac_in_reg[c];
        assign upd     = load_fall | wr_load | (hit & load_low);
        // Clamp mode tracks the short; auto mode holds the flag until revived
        assign oc_flag_next[c] = oc_now[c] | trip
                               | (~clamp_en_reg & oc_flag_reg[c] & ~revive);
        assign output_clamp[c] = ~valid_reg | ~pu_reg[c];
        assign amp_connect[c]  = ~output_clamp[c];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pu_reg[c]      <= 1'b0;
                oc_flag_reg[c] <= 1'b0;
                dac_in_reg[c]  <= 16'h0000;
                dac_out_reg[c] <= 16'h0000;
            end else if (clk_en) begin
                // A fault in the same cycle as a power-up write wins
                if (therm_trip | trip) begin
                    pu_reg[c] <= 1'b0;
                end else if (wr_pwr) begin
                    pu_reg[c] <= w_data[dpp_pkg::PU_POS[c]];
                end
                oc_flag_reg[c] <= oc_flag_next[c];
                dac_in_reg[c]  <= in_next;
                if (upd) begin
                    dac_out_reg[c] <= in_next;
                end
            end
        end
    end
    assign dac_code_a         = dac_out_reg[0];
    assign dac_code_b         = dac_out_reg[1];
    assign reference_power_up = ref_pu_reg;

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    always_comb begin
        pwr_word = 16'h0000;
        pwr_word[dpp_pkg::PU_POS[0]] = pu_reg[0];
        pwr_word[dpp_pkg::PU_POS[1]] = pu_reg[1];
        pwr_word[dpp_pkg::OC_POS[0]] = oc_flag_reg[0];
        pwr_word[dpp_pkg::OC_POS[1]] = oc_flag_reg[1];
        pwr_word[dpp_pkg::REFERENCE_POWER_UP_BIT_POS] = ref_pu_reg;
        pwr_word[dpp_pkg::TSD_POS] = tsd_flag_reg;
        rb_data = 16'h0000;
        if (w_reg == dpp_pkg::REG_DAC) begin
            rb_data = dac_in_reg[w_adr == dpp_pkg::ADR_B];
        end else if (w_reg == dpp_pkg::REG_PWR) begin
            rb_data = pwr_word;
        end else if (w_reg == dpp_pkg::REG_CTL) begin
            rb_data[dpp_pkg::CTL_CLAMP]  = clamp_en_reg;
            rb_data[dpp_pkg::CTL_TSD_EN] = tsd_en_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg    <= 24'h000000;
            bit_cnt_reg  <= 5'h00;
            rd_shift_reg <= 24'h000000;
            rb_reg       <= 24'h000000;
        end else if (clk_en) begin
            if (sync_start) begin
                bit_cnt_reg  <= 5'h00;
                rd_shift_reg <= rb_reg;
            end else if (in_frame & sclk_fall) begin
                shift_reg <= {shift_reg[22:0], filt_reg[dpp_pkg::S_SDI]};
                // Count past 24 so that an overlong word is refused too
                if (bit_cnt_reg != 5'(dpp_pkg::WORD_BITS + 1)) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
            end else if (in_frame & sclk_rise & (bit_cnt_reg != 5'h00)) begin
                rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
            end
            // A read request is answered in the next frame only
            if (word_done) begin
                rb_reg <= w_rd ? {shift_reg[23:16], rb_data} : 24'h000000;
            end
        end
    end

    // ------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------
    logic [3:0]  ista_reg;
    logic [3:0]  imsk_reg;
    logic [3:0]  events;
    logic [31:0] rd_mux;
    logic        sel_pwr;
    logic        sel_ctl;
    logic        sel_ista;
    logic        sel_imsk;
    logic        apb_wr;
    logic [31:0] prdata_reg;
    assign sel_pwr  = paddr == dpp_pkg::OFS_PWR;
    assign sel_ctl  = paddr == dpp_pkg::OFS_CTL;
    assign sel_ista = paddr == dpp_pkg::OFS_ISTA;
    assign sel_imsk = paddr == dpp_pkg::OFS_IMSK;
    assign apb_wr   = psel & penable & pwrite & clk_en;
    assign pready   = clk_en;
    assign pslverr  = psel & penable & ~(sel_pwr | sel_ctl | sel_ista | sel_imsk);
    assign prdata   = prdata_reg;
    assign events   = {therm_trip & ~tsd_flag_reg, oc_flag_next & ~oc_flag_reg, word_done};
    assign rd_mux   = sel_pwr  ? {16'h0000, pwr_word}
                    : sel_ctl  ? {28'h0000000, tsd_en_reg, clamp_en_reg, 2'h0}
                    : sel_ista ? {28'h0000000, ista_reg}
                    : sel_imsk ? {28'h0000000, imsk_reg} : 32'h00000000;
    assign irq      = |(ista_reg & imsk_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ista_reg   <= 4'h0;
            imsk_reg   <= 4'h0;
            prdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            // New events win over a write-one-to-clear in the same cycle
            ista_reg <= events | (ista_reg & ~((apb_wr & sel_ista) ? pwdata[3:0] : 4'h0));
            if (apb_wr & sel_imsk) begin
                imsk_reg <= pwdata[3:0];
            end
            if (psel & ~penable) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    clamp_until_valid_a: assert property (!valid_reg |-> output_clamp == 2'h3)
        else $error("output not clamped before first valid word");
    pwr_write_a: assert property (clk_en && wr_pwr && !therm_trip && !g_ch[0].trip
        |=> pu_reg[0] == $past(w_data[0]))
        else $error("channel A power-up bit not written");
    pd_isolate_a: assert property (!pu_reg[1] |-> output_clamp[1] && !amp_connect[1])
        else $error("powered-down channel B not isolated");
    clamp_mode_oc_a: assert property (clk_en && clamp_en_reg && oc_now[0] && pu_reg[0]
        && !therm_trip && !wr_pwr |=> pu_reg[0] && oc_flag_reg[0])
        else $error("clamp mode short mishandled");
    oc_autoclear_a: assert property (clk_en && clamp_en_reg && !oc_now[1]
        |=> !oc_flag_reg[1])
        else $error("clamp mode flag did not clear");
    auto_pd_a: assert property (clk_en && !clamp_en_reg && oc_now[0] && pu_reg[0]
        |=> !pu_reg[0] && oc_flag_reg[0] && output_clamp[0])
        else $error("auto power-down did not act");
    thermal_off_a: assert property (clk_en && therm_trip |=> pu_reg == 2'h0)
        else $error("thermal shutdown left a channel up");
    thermal_flag_a: assert property (clk_en && therm_trip |=> tsd_flag_reg ##1 tsd_flag_reg
        || $past(wr_pwr))
        else $error("thermal alert not set");
    ref_write_a: assert property ($changed(ref_pu_reg) |-> $past(wr_pwr))
        else $error("reference changed without a write");
    load_update_a: assert property (clk_en && load_fall && !wr_dac
        |=> dac_code_a == $past(dac_in_reg[0]))
        else $error("load strobe did not update output");

    word_c: cover property (word_done && !w_rd);
    readback_c: cover property (word_done && w_rd);
    auto_trip_c: cover property (g_ch[1].trip);
endmodule

/* File: dpp_host_model.sv */
// Purpose: Host serial master that faces the DAC power control block
// Assumes: link half period of 4 pclk, which gives the 800 ns link clock
// Notes:   serial clock idles high and stands still between frames
`timescale 1ns/1ns
module dpp_host_model (
    // Clock
    input  wire logic pclk,
    // Serial link
    output logic      serial_clock,
    output logic      serial_sync_n,
    output logic      serial_data_input,
    output logic      load_output_strobe_n,
    input  wire logic serial_data_output
);
    initial begin
        serial_clock         = 1'b1;
        serial_sync_n        = 1'b1;
        serial_data_input    = 1'b0;
        load_output_strobe_n = 1'b1;
    end

    // ------------------------------------------------------------
    // Frame: data is set while the clock is high, taken on its fall
    // ------------------------------------------------------------
    task automatic frame(input logic [23:0] w, input int nbits, output logic [23:0] rd);
        rd = '0;
        @(posedge pclk) serial_sync_n <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            serial_data_input <= w[23-i];
            repeat (4) @(posedge pclk);
            serial_clock <= 1'b0;
            repeat (4) @(posedge pclk);
            // Readback bit is sampled just before the rise that advances it
            rd = {rd[22:0], serial_data_output};
            serial_clock <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        serial_sync_n <= 1'b1;
        // A released data line must not keep showing its last bit
        serial_data_input <= ~serial_data_input;
        repeat (4) @(posedge pclk);
    endtask

    task automatic strobe(input logic level);
        @(posedge pclk) load_output_strobe_n <= level;
        repeat (8) @(posedge pclk);
    endtask
endmodule

/* File: dpp_ctrl_bench.sv */
// Purpose: Self-checking bench for the DAC power and protection block
// Assumes: clk_en held high, so every APB access has no wait state
// Notes:   serial results are checked 16 pclk after sync rises
`timescale 1ns/1ns
module dpp_ctrl_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sclk;
    logic        sync_n;
    logic        sdi;
    logic        load_n;
    logic        sdo;
    logic        supply_good;
    logic [1:0]  overcurrent_detect;
    logic        overtemp_detect;
    logic [15:0] dac_code_a;
    logic [15:0] dac_code_b;
    logic [1:0]  output_clamp;
    logic [1:0]  amp_connect;
    logic        reference_power_up;
    logic [23:0] back;
    logic [31:0] q;
    logic        err;
    int          error_cnt       = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    dpp_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_clock(sclk), .serial_sync_n(sync_n), .serial_data_input(sdi),
        .load_output_strobe_n(load_n), .serial_data_output(sdo),
        .supply_good(supply_good), .overcurrent_detect(overcurrent_detect),
        .overtemp_detect(overtemp_detect), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .output_clamp(output_clamp), .amp_connect(amp_connect),
        .reference_power_up(reference_power_up));

    dpp_host_model i_host (.pclk(pclk), .serial_clock(sclk), .serial_sync_n(sync_n),
        .serial_data_input(sdi), .load_output_strobe_n(load_n), .serial_data_output(sdo));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the completing edge settle before callers look at outputs
        @(negedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
    endtask

    task automatic send(input logic [23:0] w);
        i_host.frame(w, 24, back);
        repeat (12) @(posedge pclk);
    endtask

    task automatic settle(input logic [1:0] oc, input logic ot);
        @(posedge pclk) begin
            overcurrent_detect <= oc;
            overtemp_detect    <= ot;
        end
        repeat (12) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; supply_good = 1'b1;
        overcurrent_detect = 2'h0; overtemp_detect = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        check(output_clamp, 32'h3);
        check(amp_connect, 32'h0);
        check(reference_power_up, 32'h0);
        rd_chk(dpp_pkg::OFS_CTL, 32'h4);
        rd_chk(dpp_pkg::OFS_PWR, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 32'h1);
        check(q, 32'h0);
        // Internal reference in use here, so its power-up bit may be set
        send(24'h100015);
        rd_chk(dpp_pkg::OFS_PWR, 32'h15);
        check(reference_power_up, 32'h1);
        check(output_clamp, 32'h3);
        repeat (100) @(posedge pclk);
        send(24'h001234);
        check(dac_code_a, 32'h0);
        i_host.strobe(1'b0);
        check(dac_code_a, 32'h1234);
        send(24'h02ABCD);
        check(dac_code_b, 32'hABCD);
        check(output_clamp, 32'h0);
        check(amp_connect, 32'h3);
        i_host.strobe(1'b1);
        send(24'h045555);
        check(dac_code_a, 32'h1234);
        check(dac_code_b, 32'hABCD);
        send(24'h1C0000);
        check(dac_code_a, 32'h5555);
        check(dac_code_b, 32'h5555);
        rd_chk(dpp_pkg::OFS_ISTA, 32'h1);
        apb(1'b1, dpp_pkg::OFS_IMSK, 32'h1);
        check(irq, 32'h1);
        apb(1'b1, dpp_pkg::OFS_ISTA, 32'h1);
        check(irq, 32'h0);
        apb(1'b1, dpp_pkg::OFS_IMSK, 32'hE);
        send(24'h100011);
        check(output_clamp, 32'h2);
        check(amp_connect, 32'h1);
        check(irq, 32'h0);
        settle(2'b01, 1'b0);
        rd_chk(dpp_pkg::OFS_PWR, 32'h91);
        check(output_clamp, 32'h2);
        check(irq, 32'h1);
        settle(2'b00, 1'b0);
        rd_chk(dpp_pkg::OFS_PWR, 32'h11);
        apb(1'b1, dpp_pkg::OFS_ISTA, 32'hF);
        check(irq, 32'h0);
        send(24'h190000);
        rd_chk(dpp_pkg::OFS_CTL, 32'h0);
        settle(2'b01, 1'b0);
        settle(2'b00, 1'b0);
        rd_chk(dpp_pkg::OFS_PWR, 32'h90);
        check(output_clamp, 32'h3);
        send(24'h100011);
        rd_chk(dpp_pkg::OFS_PWR, 32'h11);
        settle(2'b00, 1'b1);
        settle(2'b00, 1'b0);
        rd_chk(dpp_pkg::OFS_PWR, 32'h11);
        send(24'h19000C);
        rd_chk(dpp_pkg::OFS_CTL, 32'hC);
        settle(2'b00, 1'b1);
        settle(2'b00, 1'b0);
        rd_chk(dpp_pkg::OFS_PWR, 32'h30);
        check(output_clamp, 32'h3);
        check(irq, 32'h1);
        i_host.frame(24'h100015, 23, back);
        repeat (12) @(posedge pclk);
        rd_chk(dpp_pkg::OFS_PWR, 32'h30);
        send(24'h900000);
        i_host.frame(24'h180000, 24, back);
        check(back, {8'h0, 8'h90, 16'h0030});
        end_of_test();
    end
endmodule
